// ### srcs_baud_gen.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Oversample tick: 16 per bit
// ------------------------------------------------------------
module srcs_baud_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       high_speed_baud,
  input  wire logic [7:0] baud_divisor,
  output logic            tick
);
  logic [9:0] cnt_r;
  logic [9:0] top;

  // Prescale 4 in low speed gives 64*(n+1) per bit with 16 ticks
  assign top = high_speed_baud ? {2'b00, baud_divisor}
                               : 10'({baud_divisor, 2'b11});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 10'h000;
      tick  <= 1'b0;
    end else if (!run || cnt_r >= top) begin
      cnt_r <= 10'h000;
      tick  <= run;
    end else begin
      cnt_r <= cnt_r + 10'h001;
      tick  <= 1'b0;
    end
  end
endmodule

// ### srcs_bench.sv
`timescale 1ns/100ps
module srcs_bench;
  localparam logic [7:0] A_CT = srcs_pkg::ADDR_RX_CTRL;
  localparam logic [7:0] A_MD = srcs_pkg::ADDR_MODE;
  localparam logic [7:0] A_DV = srcs_pkg::ADDR_DIVISOR;
  localparam logic [7:0] A_DT = srcs_pkg::ADDR_RX_DATA;
  localparam logic [7:0] A_ST = srcs_pkg::ADDR_IRQ_ST;
  localparam logic [7:0] A_MK = srcs_pkg::ADDR_IRQ_MSK;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line;
  logic        sclk;
  logic        sclk_oe_n;
  logic        irq;
  logic [31:0] rv;
  logic [31:0] w;
  logic        er;
  logic [8:0]  d;
  logic [7:0]  regs [6] = '{A_CT, A_MD, A_DV, A_DT, A_ST, A_MK};
  int          err_total = 0;
  int          checks_done = 0;

  always #2.5 pclk = ~pclk;

  srcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data_in(line), .rx_data_out(), .rx_data_oe_n(),
    .tx_clk_in(1'b0), .tx_clk_out(sclk), .tx_clk_oe_n(sclk_oe_n), .irq(irq));
  srcs_partner far (.pclk(pclk), .sclk(sclk), .line(line));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_total++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rv, exp);
  endtask

  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (irq !== 1'b1) err_total++;
  endtask

  task summarize;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h9191b329));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rdc(regs[i], 32'h0);
    repeat (4) begin
      w = $urandom;
      apb(1'b1, A_CT, w);
      rdc(A_CT, w & 32'h0000_00f8);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rv, 32'h0);
    $display("register access done");
    apb(1'b1, A_MD, 32'h2);
    apb(1'b1, A_DV, 32'h9);
    apb(1'b1, A_MK, 32'h7);
    apb(1'b1, A_CT, 32'h90);
    d = 9'($urandom) & 9'h0ff;
    far.send(d, 8, 160, 1'b1);
    wait_irq;
    rdc(A_DT, {24'h0, d[7:0]});
    rdc(A_ST, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    $display("fast 8-bit frame done");
    d = 9'($urandom) & 9'h0ff;
    far.send(d, 8, 160, 1'b0);
    wait_irq;
    rdc(A_CT, 32'h94);
    rdc(A_DT, {24'h0, d[7:0]});
    rdc(A_ST, 32'h3);
    $display("framing error done");
    apb(1'b1, A_MD, 32'h0);
    apb(1'b1, A_DV, 32'h19);
    apb(1'b1, A_CT, 32'hd0);
    d = 9'($urandom) | 9'h100;
    far.send(d, 9, 64 * 26, 1'b1);
    wait_irq;
    rdc(A_CT, 32'hd1);
    rdc(A_DT, {24'h0, d[7:0]});
    rdc(A_ST, 32'h1);
    $display("slow 9-bit frame done");
    apb(1'b1, A_MD, 32'h2);
    apb(1'b1, A_DV, 32'h9);
    apb(1'b1, A_CT, 32'h90);
    // Second frame lands while the first is still unread
    far.send(9'h0a5, 8, 160, 1'b1);
    far.send(9'h05a, 8, 160, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_CT, 32'h0);
    check(rv & 32'h2, 32'h2);
    apb(1'b0, A_ST, 32'h0);
    check(rv & 32'h4, 32'h4);
    apb(1'b1, A_CT, 32'h80);
    rdc(A_CT, 32'h80);
    apb(1'b0, A_DT, 32'h0);
    $display("overrun done");
    far.send(9'h0c3, 8, 160, 1'b1);
    repeat (20) @(posedge pclk);
    rdc(A_ST, 32'h0);
    apb(1'b1, A_MK, 32'h0);
    apb(1'b1, A_CT, 32'h90);
    far.send(9'h03c, 8, 160, 1'b1);
    repeat (20) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, A_MK, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    rdc(A_ST, 32'h1);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    $display("receiver off and mask done");
    rdc(A_DT, 32'h3c);
    apb(1'b1, A_CT, 32'h80);
    apb(1'b1, A_MD, 32'h1);
    d = 9'($urandom) & 9'h0ff;
    fork
      apb(1'b1, A_CT, 32'ha0);
      far.send_sync(d, 8);
    join
    check({31'h0, sclk_oe_n}, 32'h1);
    rdc(A_DT, {23'h0, d});
    rdc(A_CT, 32'h80);
    $display("sync single frame done");
    d = 9'($urandom) & 9'h0ff;
    fork
      apb(1'b1, A_CT, 32'hb0);
      far.send_sync(d, 8);
    join
    check({31'h0, sclk_oe_n}, 32'h0);
    fork
      rdc(A_DT, {23'h0, d});
      far.send_sync(~d & 9'h0ff, 8);
    join
    rdc(A_DT, {23'h0, ~d & 9'h0ff});
    rdc(A_CT, 32'hb0);
    apb(1'b1, A_CT, 32'h80);
    $display("sync continuous frames done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_CT, 32'h0);
    rdc(A_MD, 32'h0);
    $display("second reset done");
    summarize;
  end

  // Whole run is about 145 us; allow well over twice that before giving up
  initial begin
    #400us;
    err_total++;
    summarize;
  end
endmodule

// ### srcs_partner.sv
`timescale 1ns/100ps
module srcs_partner (
  input  logic pclk,
  input  logic sclk,
  output logic line
);
  initial line = 1'b1;
  // Idle high, start low, LSB first, stop high unless a bad frame is wanted
  task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stop_ok);
    for (int i = -1; i <= nb; i++) begin
      line <= (i < 0) ? 1'b0 : (i == nb) ? stop_ok : d[i];
      repeat (bc) @(posedge pclk);
    end
    line <= 1'b1;
    @(posedge pclk);
  endtask
  // Sync slave: new bit after the clock falls, held through the next rise
  task automatic send_sync(input logic [8:0] d, input int nb);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      do begin
        @(posedge pclk);
      end while (sclk !== 1'b1);
      do begin
        @(posedge pclk);
      end while (sclk !== 1'b0);
    end
  endtask
endmodule

// ### srcs_pkg.sv
package srcs_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h04;
  localparam logic [7:0] ADDR_DIVISOR = 8'h08;
  localparam logic [7:0] ADDR_RX_DATA = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

  localparam int BIT_ON     = 7;
  localparam int BIT_NINE   = 6;
  localparam int BIT_SINGLE = 5;
  localparam int BIT_CONT   = 4;
  localparam int BIT_ADDR   = 3;
  localparam int BIT_FRAME  = 2;
  localparam int BIT_OVER   = 1;
  localparam int BIT_NINTH  = 0;

  localparam int MODE_SYNC  = 0;
  localparam int MODE_HIGH  = 1;
  localparam int MODE_SLAVE = 2;

  localparam int IRQ_RX    = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_OVER  = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hf8;
  localparam logic [7:0] DIV_RESET  = 8'h00;

  localparam int LOW_SPEED_MULT  = 64;
  localparam int HIGH_SPEED_MULT = 16;
  localparam int OVERSAMPLE      = 16;
  localparam int MID_SAMPLE      = 8;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_err;
  } srcs_frame_t;
endpackage

// ### srcs_properties.sv
`timescale 1ns/100ps
module srcs_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        rx_data_out,
  input logic        rx_data_oe_n,
  input logic        tx_clk_out,
  input logic        tx_clk_oe_n,
  input logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing in first access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && paddr > srcs_pkg::ADDR_IRQ_MSK |=> pslverr)
    else $error("unmapped address not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_ctrl_upper_zero: assert property (
    pready && !pwrite && paddr == srcs_pkg::ADDR_RX_CTRL |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("control read malformed");
  a_rx_pin_input: assert property (rx_data_oe_n && rx_data_out)
    else $error("receive pin driven");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready && !pslverr)
    else $error("outputs active right after reset");
  a_clk_parked: assert property (tx_clk_oe_n |-> !tx_clk_out)
    else $error("sync clock toggles while pin released");
endmodule

bind srcs_top srcs_props u_props (.*);

// ### srcs_top.sv
`timescale 1ns/100ps
module srcs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_data_in,
  output logic             rx_data_out,
  output logic             rx_data_oe_n,
  input  wire logic        tx_clk_in,
  output logic             tx_clk_out,
  output logic             tx_clk_oe_n,
  output logic             irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} srcs_state_t;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [2:0]  mode_r;
  logic [7:0]  div_r;
  logic [8:0]  hold_r;
  logic        full_r;
  logic [2:0]  ist_r;
  logic [2:0]  imsk_r;
  srcs_state_t st_r;
  logic [3:0]  os_r;
  logic [3:0]  bit_r;
  logic [8:0]  sh_r;
  logic [6:0]  sclk_r;
  logic        sclk_prev_r;

  wire serial_port_on     = ctrl_r[srcs_pkg::BIT_ON];
  wire nine_bit_rx_select = ctrl_r[srcs_pkg::BIT_NINE];
  wire single_rx_request  = ctrl_r[srcs_pkg::BIT_SINGLE];
  wire continuous_rx_on   = ctrl_r[srcs_pkg::BIT_CONT];
  wire addr_detect_on     = ctrl_r[srcs_pkg::BIT_ADDR];
  wire sync_mode          = mode_r[srcs_pkg::MODE_SYNC];
  wire slave_mode         = mode_r[srcs_pkg::MODE_SLAVE];

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire a_ctrl  = paddr == srcs_pkg::ADDR_RX_CTRL;
  wire a_mode  = paddr == srcs_pkg::ADDR_MODE;
  wire a_div   = paddr == srcs_pkg::ADDR_DIVISOR;
  wire a_data  = paddr == srcs_pkg::ADDR_RX_DATA;
  wire a_ist   = paddr == srcs_pkg::ADDR_IRQ_ST;
  wire a_imsk  = paddr == srcs_pkg::ADDR_IRQ_MSK;
  wire a_hit   = a_ctrl || a_mode || a_div || a_data || a_ist || a_imsk;
  wire wr_ctrl = wr && a_ctrl;
  wire rd_data = rd && a_data;

  logic [31:0] rd_mux;
  assign rd_mux = a_ctrl ? {24'h000000, ctrl_r} :
                  a_mode ? {29'h00000000, mode_r} :
                  a_div  ? {24'h000000, div_r} :
                  a_data ? {24'h000000, hold_r[7:0]} :
                  a_ist  ? {29'h00000000, ist_r} :
                  a_imsk ? {29'h00000000, imsk_r} : 32'h00000000;

  // ------------------------------------------------------------
  // Receiver enable
  // ------------------------------------------------------------
  wire master_sync = sync_mode && !slave_mode;
  wire rx_enable   = serial_port_on &&
                     (!sync_mode ? continuous_rx_on
                                 : (continuous_rx_on ||
                                    (master_sync && single_rx_request)));
  wire single_only = master_sync && single_rx_request && !continuous_rx_on;

  // Synchronous clock: master drives, half periods of (divisor/2)+1 clocks
  wire sclk_edge  = sync_mode && !slave_mode ? (sclk_r == 7'(div_r >> 1)) : 1'b0;
  wire sclk_level = slave_mode ? tx_clk_in : tx_clk_out;
  wire sclk_rise  = sclk_level && !sclk_prev_r;

  logic tick;
  srcs_baud_gen u_baud (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (rx_enable && !sync_mode),
    .high_speed_baud (mode_r[srcs_pkg::MODE_HIGH]),
    .baud_divisor    (div_r),
    .tick            (tick)
  );

  // ------------------------------------------------------------
  // Receive engine
  // ------------------------------------------------------------
  wire [3:0] nbits    = nine_bit_rx_select ? 4'h9 : 4'h8;
  wire       a_sample = tick && os_r == 4'(srcs_pkg::MID_SAMPLE - 1);
  wire       a_mid_bit = tick && os_r == 4'(srcs_pkg::OVERSAMPLE - 1);
  wire       s_sample = sync_mode && sclk_rise;
  wire       last_bit = bit_r == nbits - 4'd1;
  wire       stop_ok  = rx_data_in;
  // Stop bit judged at its middle, not at its leading edge
  wire       async_done = !sync_mode && st_r == ST_STOP && a_mid_bit;
  wire       sync_done  = sync_mode && st_r == ST_DATA && s_sample && last_bit;
  wire [8:0] sync_word  = {rx_data_in, sh_r[8:1]} >> (nine_bit_rx_select ? 0 : 1);
  wire [8:0] word       = sync_mode ? sync_word : sh_r;
  // Address mode drops asynchronous frames whose ninth bit is clear
  wire       keep     = !(addr_detect_on && nine_bit_rx_select && !sync_mode && !word[8]);
  wire       done     = (async_done || sync_done) && keep;
  wire       overrun  = done && full_r;
  wire       deliver  = done && !full_r && !ctrl_r[srcs_pkg::BIT_OVER];
  wire       frame_e  = async_done && keep && !stop_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= ST_IDLE;
      os_r  <= 4'h0;
      bit_r <= 4'h0;
      sh_r  <= 9'h000;
    end else if (!rx_enable) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          bit_r <= 4'h0;
          os_r  <= 4'h0;
          if (sync_mode) begin
            st_r <= ST_DATA;
          end else if (tick && !rx_data_in) begin
            st_r <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            os_r <= os_r + 4'h1;
          end
          if (a_sample) begin
            st_r <= rx_data_in ? ST_IDLE : ST_DATA;
            os_r <= 4'h0;
          end
        end
        ST_DATA: begin
          if (tick) begin
            os_r <= os_r + 4'h1;
          end
          if (s_sample || a_mid_bit) begin
            sh_r  <= {rx_data_in, sh_r[8:1]};
            bit_r <= bit_r + 4'h1;
            if (last_bit) begin
              bit_r <= 4'h0;
              st_r  <= sync_mode ? ST_DATA : ST_STOP;
            end
          end
        end
        default: begin
          if (tick) begin
            os_r <= os_r + 4'h1;
          end
          if (a_mid_bit) begin
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Shift register holds left-aligned bits when eight-bit frames end
  wire [8:0] async_word = nine_bit_rx_select ? sh_r : {1'b0, sh_r[8:1]};
  wire [8:0] got_word   = sync_mode ? sync_word : async_word;

  // ------------------------------------------------------------
  // Control/status register
  // ------------------------------------------------------------
  logic [7:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = (pwdata[7:0] & srcs_pkg::CTRL_WMASK) |
                 (ctrl_r & ~srcs_pkg::CTRL_WMASK);
    end
    if (!ctrl_nxt[srcs_pkg::BIT_CONT]) begin
      ctrl_nxt[srcs_pkg::BIT_OVER] = 1'b0;
    end
    if (overrun) begin
      ctrl_nxt[srcs_pkg::BIT_OVER] = 1'b1;
    end
    if (sync_done && single_only) begin
      ctrl_nxt[srcs_pkg::BIT_SINGLE] = 1'b0;
    end
    if (deliver) begin
      ctrl_nxt[srcs_pkg::BIT_FRAME] = frame_e;
      ctrl_nxt[srcs_pkg::BIT_NINTH] = got_word[8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= srcs_pkg::CTRL_RESET;
      mode_r <= 3'h0;
      div_r  <= srcs_pkg::DIV_RESET;
      imsk_r <= 3'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr && a_mode) begin
        mode_r <= pwdata[2:0];
      end
      if (wr && a_div) begin
        div_r <= pwdata[7:0];
      end
      if (wr && a_imsk) begin
        imsk_r <= pwdata[2:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Holding register, interrupts, bus answer, pins
  // ------------------------------------------------------------
  wire [2:0] ev = {overrun, deliver && frame_e, deliver};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r      <= 9'h000;
      full_r      <= 1'b0;
      ist_r       <= 3'h0;
      irq         <= 1'b0;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      rx_data_out <= 1'b1;
      rx_data_oe_n <= 1'b1;
      tx_clk_out  <= 1'b0;
      tx_clk_oe_n <= 1'b1;
      sclk_r      <= 7'h00;
      sclk_prev_r <= 1'b0;
    end else begin
      if (deliver) begin
        hold_r <= got_word;
        full_r <= 1'b1;
      end else if (rd_data) begin
        full_r <= 1'b0;
      end
      // Set wins over read-clear
      ist_r  <= (rd && a_ist ? 3'h0 : ist_r) | ev;
      irq    <= |(((rd && a_ist ? 3'h0 : ist_r) | ev) & imsk_r);
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !a_hit;
      prdata  <= rd_mux;
      // Clock pin driven only while enabled as sync master; data pin never driven
      rx_data_oe_n <= 1'b1;
      tx_clk_oe_n  <= !(serial_port_on && master_sync && rx_enable);
      sclk_prev_r  <= sclk_level;
      if (!(serial_port_on && master_sync && rx_enable)) begin
        sclk_r     <= 7'h00;
        tx_clk_out <= 1'b0;
      end else if (sclk_edge) begin
        sclk_r     <= 7'h00;
        tx_clk_out <= !tx_clk_out;
      end else begin
        sclk_r <= sclk_r + 7'h01;
      end
    end
  end
endmodule
